//--- rtl/epd_top.sv
// encoder pulse divider: encoder counts in, divided quadrature out
// assumes all inputs synchronous to ref_clk; reset stands for power-up
`timescale 1ns/100ps
module epd_top
    import epd_pkg::*;
#(
    parameter int W = 31
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [epd_pkg::EPD_W-1:0] divider_rate_setting,
    input wire logic factory_default,
    input wire logic [epd_pkg::EPD_W-1:0] enc_resolution,
    input wire logic enc_step,
    input wire logic enc_dir,
    input wire logic [15:0] motor_speed,
    output logic pulse_a,
    output logic pulse_b,
    output logic alarm_setting,
    output logic alarm_overspeed
);
    import epd_pkg::*;
    if (W != EPD_W)
        $error("epd_top: W must equal the 31-bit rate width");

    typedef enum logic [1:0] {ST_LOAD, ST_DIV, ST_RUN} epd_state_e;
    typedef struct packed {
        epd_state_e st;
        logic start;
        logic [EPD_W-1:0] raw;
        logic [EPD_W-1:0] res;
        logic [EPD_W-1:0] rate;
        logic [EPD_W-1:0] n;
        logic [EPD_W-1:0] frac;
        logic [EPD_W-1:0] acc;
        logic [EPD_W-1:0] cnt;
        logic [EPD_W-1:0] per;
        logic [1:0] ph;
        logic pa;
        logic pb;
        logic al_set;
        logic al_ovs;
    } epd_top_s;
    epd_top_s s;
    epd_top_s next_s;
    epd_div_if #(.W(EPD_W)) div_bus ();

    epd_ratio u_ratio (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .d(div_bus)
    );

    function automatic logic setting_ok(input logic [EPD_W-1:0] r,
        input logic [EPD_W-1:0] res);
        logic [EPD_W-1:0] mask;
        begin
            mask = '0;
            if (r > EPD_GRID8_LIM)
                mask = 31'h0000_000f;
            else if (r > EPD_GRID4_LIM)
                mask = 31'h0000_0007;
            else if (r > EPD_GRID2_LIM)
                mask = 31'h0000_0003;
            else if (r > EPD_FINE_LIM)
                mask = 31'h0000_0001;
            if (res < EPD_HIRES_MIN)
                mask = '0;
            setting_ok = (r >= EPD_MIN_RATE) && (r <= EPD_MAX_RATE)
                && ((r & mask) == '0);
        end
    endfunction

    // period of the next output step carries the dropped fraction
    function automatic logic frac_carry(input logic [EPD_W-1:0] acc,
        input logic [EPD_W-1:0] frac, input logic [EPD_W-1:0] rate);
        frac_carry = ({1'b0, acc} + {1'b0, frac}) >= {1'b0, rate};
    endfunction

    logic [EPD_W-1:0] eff;
    logic [46:0] speed_x_rate;
    logic carry;
    logic step_fwd;
    logic step_rev;
    always_comb
    begin
        next_s = s;
        next_s.start = 1'b0;
        eff = (s.raw > s.res) ? s.res : s.raw;
        if (eff < EPD_MIN_RATE)
            eff = EPD_MIN_RATE;
        speed_x_rate = 47'(motor_speed) * 47'(s.rate);
        carry = frac_carry(s.acc, s.frac, s.rate);
        step_fwd = 1'b0;
        step_rev = 1'b0;
        case (s.st)
            ST_LOAD:
            begin
                // setting sampled once per power-up only
                next_s.raw = factory_default ? EPD_DEF_RATE
                    : divider_rate_setting;
                next_s.res = enc_resolution;
                next_s.st = ST_DIV;
            end
            ST_DIV:
            begin
                if (!s.start && s.rate == '0)
                begin
                    next_s.rate = eff;
                    next_s.al_set = !setting_ok(s.raw, s.res);
                    next_s.start = 1'b1;
                end
                else if (div_bus.done)
                begin
                    next_s.n = div_bus.quotient;
                    next_s.frac = div_bus.remainder;
                    next_s.per = div_bus.quotient;
                    next_s.st = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (s.rate <= EPD_FINE_LIM)
                    next_s.al_ovs = motor_speed > EPD_SPEED_LIM;
                else
                    next_s.al_ovs = speed_x_rate > EPD_SPEED_NUM;
                // count encoder steps, emit one output edge per period
                if (enc_step && enc_dir)
                begin
                    if (s.cnt >= s.per - 31'h1)
                    begin
                        step_fwd = 1'b1;
                        next_s.cnt = '0;
                        // uneven periods are the scatter of rates that leave a remainder of res / rate
                        next_s.per = s.n + EPD_W'(carry);
                        next_s.acc = carry ? s.acc + s.frac - s.rate
                            : s.acc + s.frac;
                    end
                    else
                        next_s.cnt = s.cnt + 31'h1;
                end
                else if (enc_step)
                begin
                    // reverse reuses the plain ratio; the fraction is ignored
                    if (s.cnt == '0)
                    begin
                        step_rev = 1'b1;
                        next_s.cnt = s.n - 31'h1;
                    end
                    else
                        next_s.cnt = s.cnt - 31'h1;
                end
                if (step_fwd)
                    next_s.ph = s.ph + 2'h1;
                else if (step_rev)
                    next_s.ph = s.ph - 2'h1;
                next_s.pa = next_s.ph[1];
                next_s.pb = next_s.ph[1] ^ next_s.ph[0];
            end
            default:
                next_s.st = ST_LOAD;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            s <= '0;
        else
            s <= next_s;
    end

    assign div_bus.start = s.start;
    assign div_bus.dividend = s.res;
    assign div_bus.divisor = s.rate;
    assign pulse_a = s.pa;
    assign pulse_b = s.pb;
    assign alarm_setting = s.al_set;
    assign alarm_overspeed = s.al_ovs;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    default_rate_a: assert property (
        s.st == ST_LOAD && factory_default |=> s.raw == EPD_DEF_RATE)
        else $error("default rate not taken");
    rate_hold_a: assert property (
        s.st == ST_RUN |=> $stable(s.rate) && $stable(s.raw))
        else $error("running rate changed");
    clamp_res_a: assert property (
        s.st == ST_RUN |-> s.rate <= s.res || s.rate == EPD_MIN_RATE)
        else $error("rate above resolution");
    range_alarm_a: assert property (
        s.st == ST_RUN && s.raw > EPD_MAX_RATE |-> alarm_setting)
        else $error("out of range rate without alarm");
    grid_alarm_a: assert property (
        s.st == ST_RUN && s.res >= EPD_HIRES_MIN && s.raw > EPD_FINE_LIM
        && s.raw <= EPD_GRID2_LIM && s.raw[0] |-> alarm_setting)
        else $error("off grid rate without alarm");
    low_speed_a: assert property (
        s.st == ST_RUN && s.rate <= EPD_FINE_LIM
        && motor_speed > EPD_SPEED_LIM |=> alarm_overspeed)
        else $error("overspeed not raised");
    ratio_a: assert property (
        s.st == ST_RUN |-> s.n == s.res / s.rate)
        else $error("wrong division ratio");
    idle_out_a: assert property (
        !enc_step |=> $stable(s.ph))
        else $error("output moved without encoder step");
    quad_dir_a: assert property (
        s.st == ST_RUN && enc_step && !enc_dir && s.cnt == '0
        |=> s.ph == $past(s.ph) - 2'h1)
        else $error("reverse step wrong");
    quad_fwd_a: assert property (
        s.st == ST_RUN && enc_step && enc_dir && s.cnt >= s.per - 31'h1
        |=> s.ph == $past(s.ph) + 2'h1)
        else $error("forward step wrong");
    scatter_a: assert property (
        s.st == ST_RUN |-> s.per == s.n || s.per == s.n + 31'h1)
        else $error("period outside n..n+1");
endmodule

//--- pkg/epd_pkg.sv
// constants shared by the encoder pulse divider modules
// assumes one 100 MHz clock and a synchronous active-low reset
package epd_pkg;
    localparam int EPD_W = 31;
    localparam logic [30:0] EPD_MIN_RATE = 31'h0000_0010;
    localparam logic [30:0] EPD_MAX_RATE = 31'h4000_0000;
    localparam logic [30:0] EPD_DEF_RATE = 31'h0000_03e8;
    localparam logic [30:0] EPD_FINE_LIM = 31'h0000_4000;
    localparam logic [30:0] EPD_HIRES_MIN = 31'h0000_8000;
    localparam logic [30:0] EPD_GRID2_LIM = 31'h0000_8000;
    localparam logic [30:0] EPD_GRID4_LIM = 31'h0001_0000;
    localparam logic [30:0] EPD_GRID8_LIM = 31'h0002_0000;
    localparam logic [15:0] EPD_SPEED_LIM = 16'h1770;
    localparam logic [46:0] EPD_SPEED_NUM = 47'h0000_05dd_7700;
    localparam logic [4:0] EPD_DIV_STEPS = 5'h1f;
endpackage

//--- pkg/epd_div_if.sv
// request and answer of the ratio divider
// assumes the master holds operands steady while busy
`timescale 1ns/100ps
interface epd_div_if #(parameter int W = 31);
    logic start;
    logic [W-1:0] dividend;
    logic [W-1:0] divisor;
    logic done;
    logic [W-1:0] quotient;
    logic [W-1:0] remainder;
    modport master (output start, dividend, divisor,
        input done, quotient, remainder);
    modport slave (input start, dividend, divisor,
        output done, quotient, remainder);
endinterface

//--- rtl/epd_ratio.sv
// sequential restoring divider, one quotient bit per cycle
// assumes operands stable from start to done
`timescale 1ns/100ps
module epd_ratio
    import epd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    epd_div_if.slave d
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [4:0] cnt;
        logic [EPD_W-1:0] quo;
        logic [EPD_W-1:0] rem;
    } epd_div_s;
    epd_div_s s;
    epd_div_s next_s;
    logic [EPD_W:0] trial;
    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        trial = {s.rem, s.quo[EPD_W-1]} - {1'b0, d.divisor};
        if (!s.busy && d.start)
        begin
            next_s.busy = 1'b1;
            next_s.cnt = EPD_DIV_STEPS;
            next_s.quo = d.dividend;
            next_s.rem = '0;
        end
        else if (s.busy)
        begin
            // quotient bits shift in where dividend bits shift out
            if (!trial[EPD_W])
                next_s.rem = trial[EPD_W-1:0];
            else
                next_s.rem = {s.rem[EPD_W-2:0], s.quo[EPD_W-1]};
            next_s.quo = {s.quo[EPD_W-2:0], ~trial[EPD_W]};
            next_s.cnt = s.cnt - 5'h01;
            if (s.cnt == 5'h01)
            begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            s <= '0;
        else
            s <= next_s;
    end
    assign d.done = s.done;
    assign d.quotient = s.quo;
    assign d.remainder = s.rem;
endmodule

//--- sim/epd_qcount.sv
// quadrature up/down counter standing in for the external controller
// assumes pulse_a and pulse_b are registered on ref_clk
`timescale 1ns/100ps
module epd_qcount
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic pulse_a,
    input wire logic pulse_b,
    output logic [15:0] count
);
    logic [1:0] ph;
    logic [1:0] next_ph;
    assign next_ph = {pulse_a, pulse_a ^ pulse_b};
    // every phase edge is decoded, so a skipped quadrature step shows
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            ph <= 2'h0;
            count <= 16'h0000;
        end
        else
        begin
            ph <= next_ph;
            if (next_ph == ph + 2'h1)
                count <= count + 16'h0001;
            else if (next_ph == ph - 2'h1)
                count <= count - 16'h0001;
            else if (next_ph != ph)
                count <= 16'hbad0; // both phases moved in one cycle
        end
    end
endmodule

//--- sim/tb.sv
// self-checking bench for the encoder pulse divider
// assumes the quadrature counter model stands in for the controller
`timescale 1ns/100ps
module tb;
    import epd_pkg::*;
    logic ref_clk, rst_b, factory_default, enc_step, enc_dir;
    logic [EPD_W-1:0] divider_rate_setting, enc_resolution;
    logic [15:0] motor_speed, count;
    logic pulse_a, pulse_b, alarm_setting, alarm_overspeed, obs_req;
    logic [17:0] exp_q[$];
    int num_errors = 0;
    int checks_done = 0;
    int seed = 64849;
    int k;
    epd_top u_epd_top (.ref_clk(ref_clk), .rst_b(rst_b),
        .divider_rate_setting(divider_rate_setting),
        .factory_default(factory_default), .enc_resolution(enc_resolution),
        .enc_step(enc_step), .enc_dir(enc_dir), .motor_speed(motor_speed),
        .pulse_a(pulse_a), .pulse_b(pulse_b), .alarm_setting(alarm_setting),
        .alarm_overspeed(alarm_overspeed));
    epd_qcount u_epd_qcount (.ref_clk(ref_clk), .rst_b(rst_b),
        .pulse_a(pulse_a), .pulse_b(pulse_b), .count(count));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [17:0] seen, input logic [17:0] want);
        checks_done++;
        if (seen !== want)
        begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // compares each note with the outputs once they are settled
    always @(posedge obs_req)
        check({count, alarm_setting, alarm_overspeed}, exp_q.pop_front());
    task automatic expect_now(input logic [15:0] c, input logic a_set,
        input logic a_ovs);
        repeat (4) @(negedge ref_clk);
        exp_q.push_back({c, a_set, a_ovs});
        obs_req = 1'b1;
        @(negedge ref_clk);
        obs_req = 1'b0;
    endtask
    // the setting is scrambled right after load: it must not take effect
    task automatic power_up(input logic [30:0] rate, input logic [30:0] res,
        input logic def);
        @(negedge ref_clk);
        rst_b = 1'b0;
        repeat (8) @(negedge ref_clk);
        divider_rate_setting = rate;
        enc_resolution = res;
        factory_default = def;
        rst_b = 1'b1;
        @(negedge ref_clk);
        divider_rate_setting = 31'($random(seed));
        enc_resolution = 31'($random(seed));
        factory_default = ~def;
        repeat (40) @(negedge ref_clk);
    endtask
    task automatic steps(input int n, input logic dir);
        repeat (n)
        begin
            @(negedge ref_clk);
            enc_step = 1'b1;
            enc_dir = dir;
        end
        @(negedge ref_clk);
        enc_step = 1'b0;
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #200000;
        num_errors++;
        print_verdict();
    end
    initial
    begin
        rst_b = 1'b0;
        obs_req = 1'b0;
        enc_step = 1'b0;
        enc_dir = 1'b1;
        motor_speed = 16'h0000;
        factory_default = 1'b0;
        divider_rate_setting = 31'h0000_0010;
        enc_resolution = 31'h0000_0040;
        k = 1 + ($unsigned($random(seed)) % 4);
        power_up(31'h0000_0010, 31'h0000_0040, 1'b0);
        steps(4 * k, 1'b1);
        expect_now(16'(k), 1'b0, 1'b0);
        $display("test forward done");
        power_up(31'h0000_0010, 31'h0000_0040, 1'b0);
        steps(8, 1'b0);
        expect_now(16'hfffe, 1'b0, 1'b0);
        $display("test reverse done");
        power_up(31'h0000_0064, 31'h0000_0040, 1'b0);
        steps(8, 1'b1);
        expect_now(16'h0008, 1'b0, 1'b0);
        $display("test clamp done");
        // 4000 counts at 1000 pulses: four steps per phase edge
        power_up(31'h0000_0010, 31'h0000_0fa0, 1'b1);
        steps(8, 1'b1);
        expect_now(16'h0002, 1'b0, 1'b0);
        // 100 counts at 16 pulses: ratio 6, fraction dropped
        power_up(31'h0000_0010, 31'h0000_0064, 1'b0);
        steps(12, 1'b1);
        expect_now(16'h0002, 1'b0, 1'b0);
        // a whole revolution catches the fraction up: 16 phase edges
        steps(88, 1'b1);
        expect_now(16'h0010, 1'b0, 1'b0);
        $display("test ratio done");
        power_up(31'h0000_0008, 31'h0000_0040, 1'b0);
        expect_now(16'h0000, 1'b1, 1'b0);
        power_up(31'h0000_4001, 31'h0001_0000, 1'b0);
        expect_now(16'h0000, 1'b1, 1'b0);
        power_up(31'h0000_8002, 31'h0001_0000, 1'b0);
        expect_now(16'h0000, 1'b1, 1'b0);
        power_up(31'h0000_8004, 31'h0001_0000, 1'b0);
        expect_now(16'h0000, 1'b0, 1'b0);
        power_up(EPD_MAX_RATE + 31'h10, EPD_MAX_RATE, 1'b0);
        expect_now(16'h0000, 1'b1, 1'b0);
        $display("test setting alarm done");
        power_up(31'h0000_4000, 31'h0000_8000, 1'b0);
        motor_speed = 16'($unsigned($random(seed)) % 6001);
        expect_now(16'h0000, 1'b0, 1'b0);
        motor_speed = EPD_SPEED_LIM + 16'h0001;
        expect_now(16'h0000, 1'b0, 1'b1);
        power_up(31'h0000_8000, 31'h0001_0000, 1'b0);
        motor_speed = 16'h0bba;
        expect_now(16'h0000, 1'b0, 1'b0);
        motor_speed = 16'h0bbb;
        expect_now(16'h0000, 1'b0, 1'b1);
        // rate 98400016: one r/min already lands past the limit product
        power_up(31'h05dd_7710, 31'h05dd_7710, 1'b0);
        motor_speed = 16'h0000;
        expect_now(16'h0000, 1'b0, 1'b0);
        motor_speed = 16'h0001;
        expect_now(16'h0000, 1'b0, 1'b1);
        $display("test overspeed done");
        print_verdict();
    end
endmodule
